// ===== rtl/vep_id_fmt.sv
`timescale 1ns/100ps
// Formats a pending identifier into a register word
module vep_id_fmt (
  // Pending source
  input wire logic pend_valid,
  input wire logic [vep_pkg::VEP_ID_BITS-1:0] pend_id,
  // Width select
  input wire logic wide,
  // Word out
  output logic [31:0] word
);
  import vep_pkg::*;

  always_comb begin
    word = VEP_ZERO_WORD;
    if (!pend_valid) begin
      word[VEP_ID_BITS-1:0] = VEP_SPECIAL_ID;
    end else if (wide) begin
      word[VEP_ID_BITS-1:0] = pend_id;
    end else begin
      word[15:0] = pend_id[15:0];
    end
  end
endmodule

// ===== rtl/vep_pkg.sv
// How it works
// - End-of-interrupt register: 32 bits, top eight reserved
// - Identifier width 16 or 24 per width field
// - Split bit 0: drop priority and deactivate
// - Split bit 1: drop priority only
// - End-of-interrupt write-only; pending registers read-only
// - Decode op1, CRn, CRm, op2 encodings
// - Group 1 route bit picks virtual end-of-interrupt
// - Group 0 route bit picks virtual pending read
// - Group 1 route bit picks virtual pending read
// - Group 0 read returns highest pending identifier
// - Group 1 read returns highest pending identifier
// - Unobservable pending reads return 1023 only
// - Enable bit 0 traps end-of-interrupt write to level one
// - Group 1 trap-all traps write to level two
// - Enable bit 0 traps pending reads to level one
// - Group 0 trap-all traps group 0 read
// - Group 1 trap-all traps group 1 read
package vep_pkg;
  // System register encoding fields
  localparam logic [2:0] VEP_OP1 = 3'h0;
  localparam logic [3:0] VEP_CRN = 4'hc;
  localparam logic [3:0] VEP_CRM_G0 = 4'h8;
  localparam logic [3:0] VEP_CRM_G1 = 4'hc;
  localparam logic [2:0] VEP_OP2_EOI = 3'h1;
  localparam logic [2:0] VEP_OP2_HPP = 3'h2;
  // Exception level code of the accessing core
  localparam logic [1:0] VEP_EL_ONE = 2'h1;
  // Identifier width field codes
  localparam logic [2:0] VEP_IDW_16 = 3'h0;
  localparam logic [2:0] VEP_IDW_24 = 3'h1;
  localparam logic [23:0] VEP_SPECIAL_ID = 24'h00_03ff;
  localparam logic [31:0] VEP_ZERO_WORD = 32'h0000_0000;
  localparam int VEP_ID_BITS = 24;

  typedef enum logic [1:0] {
    VEP_SEL_NONE,
    VEP_SEL_EOI1,
    VEP_SEL_HPP0,
    VEP_SEL_HPP1
  } vep_sel_t;
endpackage

// ===== rtl/vep_regs.sv
`timescale 1ns/100ps
module vep_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // System register access from the core
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_el,
  input wire logic [2:0] acc_op1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_op2,
  input wire logic [31:0] acc_wdata,
  // Access answer
  output logic acc_done_q,
  output logic [31:0] acc_rdata_q,
  output logic acc_undef_q,
  output logic trap_el1_q,
  output logic trap_el2_q,
  // Control bits from the rest of the interface
  input wire logic split_end_of_interrupt_bit,
  input wire logic [2:0] identifier_width_field,
  input wire logic group0_virtual_route_bit,
  input wire logic group1_virtual_route_bit,
  input wire logic trap_general_exceptions_bit,
  input wire logic non_secure_state_bit,
  input wire logic system_register_enable_bit,
  input wire logic group0_trap_all_bit,
  input wire logic group1_trap_all_bit,
  // Highest pending virtual interrupts
  input wire logic pend0_valid,
  input wire logic [vep_pkg::VEP_ID_BITS-1:0] pend0_id,
  input wire logic pend1_valid,
  input wire logic [vep_pkg::VEP_ID_BITS-1:0] pend1_id,
  // End-of-interrupt effects on the virtual interface
  output logic prio_drop_q,
  output logic deactivate_q,
  output logic [31:0] eoi_id_q,
  // Routes to the physical registers
  output logic phys_eoi1_wr_q,
  output logic [31:0] phys_wdata_q,
  output logic phys_hpp0_rd_q,
  output logic phys_hpp1_rd_q
);
  import vep_pkg::*;

  function automatic vep_sel_t decode_sel(input logic [2:0] op1, input logic [3:0] crn,
                                          input logic [3:0] crm, input logic [2:0] op2);
    decode_sel = VEP_SEL_NONE;
    if (op1 != VEP_OP1 || crn != VEP_CRN) begin
      decode_sel = VEP_SEL_NONE;
    end else if (crm == VEP_CRM_G1 && op2 == VEP_OP2_EOI) begin
      decode_sel = VEP_SEL_EOI1;
    end else if (crm == VEP_CRM_G0 && op2 == VEP_OP2_HPP) begin
      decode_sel = VEP_SEL_HPP0;
    end else if (crm == VEP_CRM_G1 && op2 == VEP_OP2_HPP) begin
      decode_sel = VEP_SEL_HPP1;
    end
  endfunction

  vep_sel_t sel;
  logic wide;
  logic hit;
  logic dir_ok;
  logic trap1;
  logic trap2;
  logic route;
  logic ok;
  logic virt;
  logic phys;
  logic virt_eoi;
  logic [31:0] word0;
  logic [31:0] word1;
  logic [31:0] wmask;

  assign sel = decode_sel(acc_op1, acc_crn, acc_crm, acc_op2);
  assign wide = (identifier_width_field == VEP_IDW_24);
  // Only non-secure level one accesses are handled here
  assign hit = acc_valid && acc_el == VEP_EL_ONE && non_secure_state_bit &&
               sel != VEP_SEL_NONE;
  assign dir_ok = ((sel == VEP_SEL_EOI1) == acc_write);
  assign trap1 = hit && dir_ok && !system_register_enable_bit;
  // Enable trap outranks the trap-all traps
  assign trap2 = hit && dir_ok && system_register_enable_bit && non_secure_state_bit &&
                 ((sel == VEP_SEL_HPP0) ? group0_trap_all_bit
                                         : group1_trap_all_bit);
  assign route = (sel == VEP_SEL_HPP0) ? group0_virtual_route_bit
                                       : group1_virtual_route_bit;
  assign ok = hit && dir_ok && !trap1 && !trap2;
  assign virt = ok && route && !trap_general_exceptions_bit;
  assign phys = ok && !virt;
  assign virt_eoi = virt && sel == VEP_SEL_EOI1;
  // Reserved bits of the written word are dropped on the virtual path; phys_wdata_q keeps them
  assign wmask = wide ? 32'h00ff_ffff : 32'h0000_ffff;

  vep_id_fmt u_fmt0 (
    .pend_valid(pend0_valid),
    .pend_id(pend0_id),
    .wide(wide),
    .word(word0)
  );

  vep_id_fmt u_fmt1 (
    .pend_valid(pend1_valid),
    .pend_id(pend1_id),
    .wide(wide),
    .word(word1)
  );

  // Answer strobes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_done_q <= 1'b0;
      acc_undef_q <= 1'b0;
      trap_el1_q <= 1'b0;
      trap_el2_q <= 1'b0;
    end else begin
      acc_done_q <= hit;
      acc_undef_q <= hit && !dir_ok;
      trap_el1_q <= trap1;
      trap_el2_q <= trap2;
    end
  end

  // Read data
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_rdata_q <= VEP_ZERO_WORD;
    end else if (virt && sel == VEP_SEL_HPP0) begin
      acc_rdata_q <= word0;
    end else if (virt && sel == VEP_SEL_HPP1) begin
      acc_rdata_q <= word1;
    end else begin
      acc_rdata_q <= VEP_ZERO_WORD;
    end
  end

  // Virtual end of interrupt
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prio_drop_q <= 1'b0;
      deactivate_q <= 1'b0;
      eoi_id_q <= VEP_ZERO_WORD;
    end else begin
      prio_drop_q <= virt_eoi;
      // Split mode leaves deactivation to the deactivate register
      deactivate_q <= virt_eoi && !split_end_of_interrupt_bit;
      if (virt_eoi) begin
        eoi_id_q <= acc_wdata & wmask;
      end
    end
  end

  // Physical routing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phys_eoi1_wr_q <= 1'b0;
      phys_hpp0_rd_q <= 1'b0;
      phys_hpp1_rd_q <= 1'b0;
      phys_wdata_q <= VEP_ZERO_WORD;
    end else begin
      phys_eoi1_wr_q <= phys && sel == VEP_SEL_EOI1;
      phys_hpp0_rd_q <= phys && sel == VEP_SEL_HPP0;
      phys_hpp1_rd_q <= phys && sel == VEP_SEL_HPP1;
      if (phys && sel == VEP_SEL_EOI1) begin
        phys_wdata_q <= acc_wdata;
      end
    end
  end

  // Checks
  property p_eoi_resv;
    @(posedge clk_sys) disable iff (reset)
    prio_drop_q |-> eoi_id_q[31:24] == 8'h00;
  endproperty
  a_eoi_resv: assert property (p_eoi_resv) else $error("eoi reserved bits set");

  property p_narrow;
    @(posedge clk_sys) disable iff (reset)
    (virt_eoi && identifier_width_field == VEP_IDW_16) |=> eoi_id_q[23:16] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow id kept upper bits");

  property p_joint;
    @(posedge clk_sys) disable iff (reset)
    (virt_eoi && !split_end_of_interrupt_bit) |=> prio_drop_q && deactivate_q;
  endproperty
  a_joint: assert property (p_joint) else $error("eoi did not drop and deactivate");

  property p_split;
    @(posedge clk_sys) disable iff (reset)
    (virt_eoi && split_end_of_interrupt_bit) |=> prio_drop_q && !deactivate_q;
  endproperty
  a_split: assert property (p_split) else $error("split eoi deactivated");

  property p_dir;
    @(posedge clk_sys) disable iff (reset)
    (hit && !dir_ok) |=> acc_undef_q && !prio_drop_q && !phys_hpp0_rd_q && !phys_hpp1_rd_q;
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction access acted");

  property p_eoi_route;
    @(posedge clk_sys) disable iff (reset)
    (ok && sel == VEP_SEL_EOI1) |=>
      (phys_eoi1_wr_q != prio_drop_q) &&
      (prio_drop_q == ($past(group1_virtual_route_bit) &&
                       !$past(trap_general_exceptions_bit)));
  endproperty
  a_eoi_route: assert property (p_eoi_route) else $error("eoi misrouted");

  property p_hpp0_route;
    @(posedge clk_sys) disable iff (reset)
    (ok && sel == VEP_SEL_HPP0 && !group0_virtual_route_bit) |=>
      phys_hpp0_rd_q && acc_rdata_q == VEP_ZERO_WORD;
  endproperty
  a_hpp0_route: assert property (p_hpp0_route) else $error("group 0 read misrouted");

  property p_hpp1_route;
    @(posedge clk_sys) disable iff (reset)
    (ok && sel == VEP_SEL_HPP1 && !group1_virtual_route_bit) |=> phys_hpp1_rd_q;
  endproperty
  a_hpp1_route: assert property (p_hpp1_route) else $error("group 1 read misrouted");

  property p_hpp0_data;
    @(posedge clk_sys) disable iff (reset)
    (virt && sel == VEP_SEL_HPP0 && pend0_valid && wide) |=>
      acc_rdata_q == {8'h00, $past(pend0_id)};
  endproperty
  a_hpp0_data: assert property (p_hpp0_data) else $error("group 0 id wrong");

  property p_hpp1_data;
    @(posedge clk_sys) disable iff (reset)
    (virt && sel == VEP_SEL_HPP1 && pend1_valid && wide) |=>
      acc_rdata_q == {8'h00, $past(pend1_id)};
  endproperty
  a_hpp1_data: assert property (p_hpp1_data) else $error("group 1 id wrong");

  property p_special;
    @(posedge clk_sys) disable iff (reset)
    (virt && sel == VEP_SEL_HPP1 && !pend1_valid) |=> acc_rdata_q == 32'h0000_03ff;
  endproperty
  a_special: assert property (p_special) else $error("special id not 1023");

  property p_special0;
    @(posedge clk_sys) disable iff (reset)
    (virt && sel == VEP_SEL_HPP0 && !pend0_valid) |=> acc_rdata_q == 32'h0000_03ff;
  endproperty
  a_special0: assert property (p_special0) else $error("group 0 special id not 1023");

  property p_rd_resv;
    @(posedge clk_sys) disable iff (reset)
    acc_rdata_q[31:24] == 8'h00;
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("read reserved bits set");

  property p_rd_narrow;
    @(posedge clk_sys) disable iff (reset)
    (virt && sel != VEP_SEL_EOI1 && !wide) |=> acc_rdata_q[23:16] == 8'h00;
  endproperty
  a_rd_narrow: assert property (p_rd_narrow) else $error("narrow read upper bits set");

  property p_ignore;
    @(posedge clk_sys) disable iff (reset)
    !hit |=> !acc_done_q && !prio_drop_q && !phys_eoi1_wr_q && !phys_hpp0_rd_q &&
             !phys_hpp1_rd_q;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign access answered");

  property p_one_answer;
    @(posedge clk_sys) disable iff (reset)
    acc_done_q |-> $onehot0({acc_undef_q, trap_el1_q, trap_el2_q, prio_drop_q, phys_eoi1_wr_q,
                             phys_hpp0_rd_q, phys_hpp1_rd_q});
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("more than one answer");

  property p_trap1_wr;
    @(posedge clk_sys) disable iff (reset)
    (hit && acc_write && sel == VEP_SEL_EOI1 && !system_register_enable_bit) |=>
      trap_el1_q && !trap_el2_q && !prio_drop_q && !phys_eoi1_wr_q;
  endproperty
  a_trap1_wr: assert property (p_trap1_wr) else $error("eoi not trapped to one");

  property p_trap2_wr;
    @(posedge clk_sys) disable iff (reset)
    (hit && acc_write && sel == VEP_SEL_EOI1 && system_register_enable_bit &&
     group1_trap_all_bit) |=> trap_el2_q && !prio_drop_q;
  endproperty
  a_trap2_wr: assert property (p_trap2_wr) else $error("eoi not trapped to two");

  property p_trap1_rd;
    @(posedge clk_sys) disable iff (reset)
    (hit && !acc_write && sel != VEP_SEL_EOI1 && !system_register_enable_bit) |=>
      trap_el1_q && acc_rdata_q == VEP_ZERO_WORD;
  endproperty
  a_trap1_rd: assert property (p_trap1_rd) else $error("read not trapped to one");

  property p_trap2_rd0;
    @(posedge clk_sys) disable iff (reset)
    (hit && !acc_write && sel == VEP_SEL_HPP0 && system_register_enable_bit &&
     group0_trap_all_bit) |=> trap_el2_q && !phys_hpp0_rd_q;
  endproperty
  a_trap2_rd0: assert property (p_trap2_rd0) else $error("group 0 read not trapped");

  property p_trap2_rd1;
    @(posedge clk_sys) disable iff (reset)
    (hit && !acc_write && sel == VEP_SEL_HPP1 && system_register_enable_bit &&
     group1_trap_all_bit) |=> trap_el2_q && !phys_hpp1_rd_q;
  endproperty
  a_trap2_rd1: assert property (p_trap2_rd1) else $error("group 1 read not trapped");
endmodule

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
  import vep_pkg::*;
  logic clk_sys, acc_valid, acc_write;
  logic reset = 1'b1;
  logic [1:0] acc_el;
  logic [2:0] acc_op1, acc_op2;
  logic [3:0] acc_crn, acc_crm;
  logic [31:0] acc_wdata, acc_rdata_q, eoi_id_q, phys_wdata_q;
  logic acc_done_q, acc_undef_q, trap_el1_q, trap_el2_q, prio_drop_q, deactivate_q;
  logic phys_eoi1_wr_q, phys_hpp0_rd_q, phys_hpp1_rd_q;
  logic split_end_of_interrupt_bit = 1'b0, group0_virtual_route_bit = 1'b0;
  logic group1_virtual_route_bit = 1'b0, trap_general_exceptions_bit = 1'b0;
  logic non_secure_state_bit = 1'b0, system_register_enable_bit = 1'b0;
  logic group0_trap_all_bit = 1'b0, group1_trap_all_bit = 1'b0;
  logic pend0_valid = 1'b0, pend1_valid = 1'b0;
  logic [2:0] identifier_width_field = 3'h0;
  logic [VEP_ID_BITS-1:0] pend0_id = '0, pend1_id = '0;
  logic [31:0] lf = 32'h0000_7405;
  int fail_count = 0, compares = 0;
  vep_regs i_dut (
    .clk_sys(clk_sys), .reset(reset), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_el(acc_el), .acc_op1(acc_op1), .acc_crn(acc_crn), .acc_crm(acc_crm),
    .acc_op2(acc_op2), .acc_wdata(acc_wdata), .acc_done_q(acc_done_q),
    .acc_rdata_q(acc_rdata_q), .acc_undef_q(acc_undef_q), .trap_el1_q(trap_el1_q),
    .trap_el2_q(trap_el2_q), .split_end_of_interrupt_bit(split_end_of_interrupt_bit),
    .identifier_width_field(identifier_width_field),
    .group0_virtual_route_bit(group0_virtual_route_bit),
    .group1_virtual_route_bit(group1_virtual_route_bit),
    .trap_general_exceptions_bit(trap_general_exceptions_bit),
    .non_secure_state_bit(non_secure_state_bit),
    .system_register_enable_bit(system_register_enable_bit),
    .group0_trap_all_bit(group0_trap_all_bit), .group1_trap_all_bit(group1_trap_all_bit),
    .pend0_valid(pend0_valid), .pend0_id(pend0_id), .pend1_valid(pend1_valid),
    .pend1_id(pend1_id), .prio_drop_q(prio_drop_q), .deactivate_q(deactivate_q),
    .eoi_id_q(eoi_id_q), .phys_eoi1_wr_q(phys_eoi1_wr_q), .phys_wdata_q(phys_wdata_q),
    .phys_hpp0_rd_q(phys_hpp0_rd_q), .phys_hpp1_rd_q(phys_hpp1_rd_q)
  );
  vep_core_model i_core (
    .clk_sys(clk_sys), .acc_valid(acc_valid), .acc_write(acc_write), .acc_el(acc_el),
    .acc_op1(acc_op1), .acc_crn(acc_crn), .acc_crm(acc_crm), .acc_op2(acc_op2),
    .acc_wdata(acc_wdata)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    return s;
  endfunction
  // Expected pending read word from the observable flag, width and identifier
  function automatic logic [31:0] exp_rd(input logic v, input logic w24, input logic [23:0] id);
    if (!v) begin
      return {8'h00, VEP_SPECIAL_ID};
    end
    return w24 ? {8'h00, id} : {16'h0000, id[15:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Kind: 0 virtual, 1 route off, 2 general trap bit, 3 enable off, 4 trap-all,
  // 5 wrong direction, 6 level zero, 7 other encoding, 8 secure state
  // Sel: 0 end-of-interrupt, 1 group 0 pending, 2 group 1 pending
  task automatic run(input int kind, input int sel);
    logic [31:0] mask, wd, erd;
    logic [8:0] ev;
    logic wr, virt, phys, pv;
    logic [VEP_ID_BITS-1:0] pid;
    @(negedge clk_sys);
    lf = lfsr(lf);
    {split_end_of_interrupt_bit, identifier_width_field, pend0_valid, pend1_valid} = lf[5:0];
    pend0_id = lf[31:8];
    lf = lfsr(lf);
    pend1_id = lf[23:0];
    lf = lfsr(lf);
    wd = lf;
    {group0_virtual_route_bit, group1_virtual_route_bit} =
      (kind == 1) ? ((sel == 1) ? 2'b01 : 2'b10) : 2'b11;
    trap_general_exceptions_bit = (kind == 2);
    system_register_enable_bit = (kind != 3);
    non_secure_state_bit = (kind != 8);
    {group0_trap_all_bit, group1_trap_all_bit} =
      (kind == 4) ? ((sel == 1) ? 2'b10 : 2'b01) : 2'b00;
    wr = (sel == 0) ^ (kind == 5);
    i_core.issue(wr, (kind == 6) ? 2'h0 : VEP_EL_ONE, (kind == 7 && sel == 2) ? 4'hb : VEP_CRN,
      (sel == 1) ? VEP_CRM_G0 : VEP_CRM_G1,
      (kind == 7 && sel != 2) ? 3'h0 : ((sel == 0) ? VEP_OP2_EOI : VEP_OP2_HPP), wd);
    mask = (identifier_width_field == VEP_IDW_24) ? 32'h00ff_ffff : 32'h0000_ffff;
    virt = (kind == 0);
    phys = (kind == 1 || kind == 2);
    pv = (sel == 1) ? pend0_valid : pend1_valid;
    pid = (sel == 1) ? pend0_id : pend1_id;
    erd = (virt && sel != 0) ? exp_rd(pv, identifier_width_field == VEP_IDW_24, pid)
                             : VEP_ZERO_WORD;
    ev = {kind < 6, kind == 5, kind == 3, kind == 4, virt && sel == 0,
      virt && sel == 0 && !split_end_of_interrupt_bit, phys && sel == 0,
      phys && sel == 1, phys && sel == 2};
    chk({23'h0, acc_done_q, acc_undef_q, trap_el1_q, trap_el2_q, prio_drop_q, deactivate_q,
      phys_eoi1_wr_q, phys_hpp0_rd_q, phys_hpp1_rd_q}, {23'h0, ev});
    chk(acc_rdata_q, erd);
    if (virt && sel == 0)
      chk(eoi_id_q, wd & mask);
    if (phys && sel == 0)
      chk(phys_wdata_q, wd);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    for (int k = 0; k < 9; k++) begin
      for (int s = 0; s < 3; s++) begin
        run(k, s);
      end
    end
    // Reset in mid-run
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({23'h0, acc_done_q, acc_undef_q, trap_el1_q, trap_el2_q, prio_drop_q, deactivate_q,
      phys_eoi1_wr_q, phys_hpp0_rd_q, phys_hpp1_rd_q}, 32'h0);
    chk(acc_rdata_q, VEP_ZERO_WORD);
    chk(eoi_id_q, VEP_ZERO_WORD);
    chk(phys_wdata_q, VEP_ZERO_WORD);
    reset = 1'b0;
    repeat (300) begin
      lf = lfsr(lf);
      run(lf[7:0] % 9, lf[9:8] % 3);
    end
    give_verdict();
  end
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
endmodule

// ===== test/vep_core_model.sv
`timescale 1ns/100ps
module vep_core_model (
  // Clock
  input wire logic clk_sys,
  // Access request to the register block
  output logic acc_valid,
  output logic acc_write,
  output logic [1:0] acc_el,
  output logic [2:0] acc_op1,
  output logic [3:0] acc_crn,
  output logic [3:0] acc_crm,
  output logic [2:0] acc_op2,
  output logic [31:0] acc_wdata
);
  import vep_pkg::*;
  initial begin
    {acc_valid, acc_write, acc_el, acc_op1, acc_crn, acc_crm, acc_op2, acc_wdata} = 50'h0;
  end
  // One access, no stall; identifier handed in by the caller
  task automatic issue(input logic wr, input logic [1:0] el, input logic [3:0] crn,
                       input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] wd);
    @(negedge clk_sys);
    acc_valid = 1'b1;
    {acc_write, acc_el, acc_op1, acc_crn, acc_crm, acc_op2, acc_wdata} =
      {wr, el, VEP_OP1, crn, crm, op2, wd};
    @(negedge clk_sys);
    // Released lines show the inverse of the last value
    acc_valid = 1'b0;
    {acc_write, acc_el, acc_op1, acc_crn, acc_crm, acc_op2, acc_wdata} =
      ~{acc_write, acc_el, acc_op1, acc_crn, acc_crm, acc_op2, acc_wdata};
  endtask
endmodule
